//--- hdl/atos_pkg.sv
package atos_pkg;

  // Output and channel counts
  localparam int unsigned ATOS_NUM_OUTPUTS = 8;
  localparam int unsigned ATOS_NUM_CHANNELS = 8;
  localparam int unsigned ATOS_ADDR_W = 8;
  localparam int unsigned ATOS_DATA_W = 8;

  // Mask register offsets, output0 .. output7
  localparam logic [7:0] ATOS_OUTPUT0_MASK_ADDR = 8'hc3;
  localparam logic [7:0] ATOS_OUTPUT1_MASK_ADDR = 8'hc5;
  localparam logic [7:0] ATOS_OUTPUT2_MASK_ADDR = 8'hc7;
  localparam logic [7:0] ATOS_OUTPUT3_MASK_ADDR = 8'hc9;
  localparam logic [7:0] ATOS_OUTPUT4_MASK_ADDR = 8'hcb;
  localparam logic [7:0] ATOS_OUTPUT5_MASK_ADDR = 8'hcd;
  localparam logic [7:0] ATOS_OUTPUT6_MASK_ADDR = 8'hcf;
  localparam logic [7:0] ATOS_OUTPUT7_MASK_ADDR = 8'hd1;

  // Address step between consecutive mask registers
  localparam logic [7:0] ATOS_MASK_ADDR_STEP = 8'h02;

  // Reset value of every mask register: channel one only
  localparam logic [7:0] ATOS_MASK_RESET = 8'h02;

  // Value returned on unmapped reads
  localparam logic [7:0] ATOS_UNMAPPED_READ = 8'h00;

endpackage

//--- hdl/atos_mask_reg.sv
`timescale 1ns/10ps
module atos_mask_reg (
  // Clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_reset,
  // Write port
  input  wire logic                         i_wr_en,
  input  wire logic [atos_pkg::ATOS_DATA_W-1:0] i_wr_data,
  // Stored mask
  output logic      [atos_pkg::ATOS_DATA_W-1:0] o_mask
);
  import atos_pkg::*;

  typedef struct packed {
    logic [ATOS_DATA_W-1:0] mask;
  } atos_mreg_s;

  atos_mreg_s state_q;
  atos_mreg_s state_d;

  always_comb begin
    state_d = state_q;
    if (i_wr_en) begin
      state_d.mask = i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q.mask <= ATOS_MASK_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_mask = state_q.mask;

endmodule

//--- hdl/atos_top.sv
`timescale 1ns/10ps
module atos_top (
  // Clock and reset
  input  wire logic                                   i_clk,
  input  wire logic                                   i_reset,
  // Register port
  input  wire logic [atos_pkg::ATOS_ADDR_W-1:0]       i_addr,
  input  wire logic [atos_pkg::ATOS_DATA_W-1:0]       i_wdata,
  input  wire logic                                   i_wr,
  input  wire logic                                   i_rd,
  output logic      [atos_pkg::ATOS_DATA_W-1:0]       o_rdata,
  // Alert flags per channel, same clock
  input  wire logic [atos_pkg::ATOS_NUM_CHANNELS-1:0] i_alert,
  // Update strobes per general output pin
  output logic      [atos_pkg::ATOS_NUM_OUTPUTS-1:0]  o_update
);
  import atos_pkg::*;

  typedef struct packed {
    logic [ATOS_DATA_W-1:0]     rdata;
    logic [ATOS_NUM_OUTPUTS-1:0] update;
  } atos_top_s;

  atos_top_s state_q;
  atos_top_s state_d;

  logic [ATOS_DATA_W-1:0]      mask [ATOS_NUM_OUTPUTS];
  logic [ATOS_NUM_OUTPUTS-1:0] wr_sel;

  // Decode result for an address outside the mask block
  localparam logic [3:0] ATOS_NO_MASK = 4'(ATOS_NUM_OUTPUTS);

  // Mask index for a register address
  function automatic logic [3:0] atos_decode(input logic [ATOS_ADDR_W-1:0] addr);
    logic [3:0] idx;
    // Odd addresses only; even neighbours stay unmapped
    case (addr)
      ATOS_OUTPUT0_MASK_ADDR: begin
        idx = 4'h0;
      end
      ATOS_OUTPUT1_MASK_ADDR: begin
        idx = 4'h1;
      end
      ATOS_OUTPUT2_MASK_ADDR: begin
        idx = 4'h2;
      end
      ATOS_OUTPUT3_MASK_ADDR: begin
        idx = 4'h3;
      end
      ATOS_OUTPUT4_MASK_ADDR: begin
        idx = 4'h4;
      end
      ATOS_OUTPUT5_MASK_ADDR: begin
        idx = 4'h5;
      end
      ATOS_OUTPUT6_MASK_ADDR: begin
        idx = 4'h6;
      end
      ATOS_OUTPUT7_MASK_ADDR: begin
        idx = 4'h7;
      end
      default: begin
        idx = ATOS_NO_MASK;
      end
    endcase
    return idx;
  endfunction

  // Load strobe per mask; unmapped writes select nothing
  function automatic logic [ATOS_NUM_OUTPUTS-1:0] atos_onehot(input logic       en,
                                                              input logic [3:0] idx);
    logic [ATOS_NUM_OUTPUTS-1:0] sel;
    sel = '0;
    if (en && (idx < ATOS_NO_MASK)) begin
      sel[idx[2:0]] = 1'b1;
    end
    return sel;
  endfunction

  // An output updates when any alert of a selected channel is up
  function automatic logic atos_gate(input logic [ATOS_DATA_W-1:0]       sel_mask,
                                     input logic [ATOS_NUM_CHANNELS-1:0] alert);
    return |(sel_mask & alert);
  endfunction

  // At most one mask loads per write
  always_comb begin
    wr_sel = atos_onehot(i_wr, atos_decode(i_addr));
  end

  // One mask register per output, each reset to channel one only
  atos_mask_reg u_mask0 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[0]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[0])
  );

  atos_mask_reg u_mask1 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[1]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[1])
  );

  atos_mask_reg u_mask2 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[2]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[2])
  );

  atos_mask_reg u_mask3 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[3]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[3])
  );

  atos_mask_reg u_mask4 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[4]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[4])
  );

  atos_mask_reg u_mask5 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[5]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[5])
  );

  atos_mask_reg u_mask6 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[6]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[6])
  );

  atos_mask_reg u_mask7 (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_wr_en   (wr_sel[7]),
    .i_wr_data (i_wdata),
    .o_mask    (mask[7])
  );

  // Next read data and update requests
  always_comb begin
    logic [3:0] ridx;
    ridx = atos_decode(i_addr);
    state_d = state_q;
    // Read data stands for one cycle only
    state_d.rdata = ATOS_UNMAPPED_READ;
    if (i_rd) begin
      case (ridx)
        4'h0: begin
          state_d.rdata = mask[0];
        end
        4'h1: begin
          state_d.rdata = mask[1];
        end
        4'h2: begin
          state_d.rdata = mask[2];
        end
        4'h3: begin
          state_d.rdata = mask[3];
        end
        4'h4: begin
          state_d.rdata = mask[4];
        end
        4'h5: begin
          state_d.rdata = mask[5];
        end
        4'h6: begin
          state_d.rdata = mask[6];
        end
        4'h7: begin
          state_d.rdata = mask[7];
        end
        default: begin
          state_d.rdata = ATOS_UNMAPPED_READ;
        end
      endcase
    end
    // Bit n of every mask gates channel n
    state_d.update[0] = atos_gate(mask[0], i_alert);
    state_d.update[1] = atos_gate(mask[1], i_alert);
    state_d.update[2] = atos_gate(mask[2], i_alert);
    state_d.update[3] = atos_gate(mask[3], i_alert);
    state_d.update[4] = atos_gate(mask[4], i_alert);
    state_d.update[5] = atos_gate(mask[5], i_alert);
    state_d.update[6] = atos_gate(mask[6], i_alert);
    state_d.update[7] = atos_gate(mask[7], i_alert);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_rdata  = state_q.rdata;
  assign o_update = state_q.update;

endmodule

//--- sim/atos_top_assertions.sv
`timescale 1ns/10ps
module atos_chk (
  input logic i_clk,
  input logic i_reset,
  input logic i_rd,
  input logic i_wr,
  input logic [7:0] i_addr,
  input logic [7:0] i_wdata,
  input logic [7:0] o_rdata,
  input logic [7:0] i_alert,
  input logic [7:0] o_update
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("rdata not idle");
  upd_cause_a: assert property (!$past(i_alert) |-> o_update == 8'h00)
    else $error("update no alert");
  upd_reset_a: assert property ($fell(i_reset) && !i_wr |=> o_update == {8{$past(i_alert[1])}})
    else $error("reset mask");
  logic mapped;
  assign mapped = i_addr inside {8'hc3, 8'hc5, 8'hc7, 8'hc9, 8'hcb, 8'hcd, 8'hcf, 8'hd1};
  sequence wr_gap_rd_s;
    (i_wr && mapped) ##1 !i_wr ##1 (i_rd && i_addr == $past(i_addr, 2));
  endsequence
  sequence rst_rd_s;
    $fell(i_reset) ##1 (i_rd && mapped);
  endsequence
  rd_unmapped_a: assert property (i_rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read data");
  wr_readback_a: assert property (wr_gap_rd_s |=> o_rdata == $past(i_wdata, 3))
    else $error("readback differs");
  rst_readback_a: assert property (rst_rd_s |=> o_rdata == 8'h02)
    else $error("mask not reset");
endmodule
bind atos_top atos_chk u_chk (.i_clk, .i_reset, .i_rd, .i_wr, .i_addr, .i_wdata, .o_rdata, .i_alert, .o_update);

//--- sim/atos_top_tb.sv
`timescale 1ns/10ps
module atos_top_tb;
  logic i_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, i_alert = 0, o_rdata, o_update, r;
  int miscompares = 0, samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  atos_top uut (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_alert, .o_update);
  task chk(input string n, input logic [7:0] s, x);
    samples_checked++;
    miscompares += s !== x;
    if (s !== x) $display("ERROR %s exp %h got %h", n, x, s);
  endtask
  task bus(input logic w, input logic [7:0] a, d);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 0;
    i_rd <= 0;
    @(negedge i_clk) if (!w) chk("rdata", o_rdata, d);
    @(posedge i_clk);
  endtask
  task upd(input logic [7:0] a, x);
    i_alert <= a;
    @(posedge i_clk);
    @(negedge i_clk) chk("update", o_update, x);
    @(posedge i_clk);
  endtask
  task wrap_up(input int extra);
    miscompares += extra;
    $display("checks %0d errors %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial #20000 wrap_up(1);
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 0;
    @(posedge i_clk);
    for (int k = 0; k < 8; k++) begin
      r = 8'hc3 + 8'(2 * k);
      bus(0, r, 8'h02);
      bus(1, r, 8'h01 << k);
      bus(0, r, 8'h01 << k);
      upd(8'h01 << k, (8'h01 << k) | (k == 1 ? 8'hfc : 8'h00));
    end
    bus(1, 8'hc3, 8'h81);
    bus(1, 8'hc4, 8'hff);
    bus(0, 8'hc4, 8'h00);
    upd(8'h80, 8'h81);
    upd(8'h01, 8'h01);
    upd(8'h7e, 8'h7e);
    i_reset <= 1;
    repeat (3) @(posedge i_clk);
    i_reset <= 0;
    @(posedge i_clk);
    bus(0, 8'hd1, 8'h02);
    bus(0, 8'hc3, 8'h02);
    upd(8'h02, 8'hff);
    wrap_up(0);
  end
endmodule
